// ### eeprom_port_consts.svh
// Constants for the two-wire secure EEPROM port
`ifndef EEPROM_PORT_CONSTS_SVH
`define EEPROM_PORT_CONSTS_SVH

// ----------------------------------------------------------------
// User memory layout
// ----------------------------------------------------------------
`define EE_ZONE_COUNT      16
`define EE_ZONE_BITS       4096
`define EE_ZONE_BYTES      512
`define EE_ZONE_W          4
`define EE_LOCAL_W         9
`define EE_ADDR_W          13
`define EE_LOCAL_BASE      9'h000
`define EE_LOCAL_LAST      9'h1ff
`define EE_LAST_ZONE       4'hf
`define EE_CLASS_W         4

// ----------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------
`define EE_WORD_BITS       8
`define EE_BITCNT_FULL     4'h8
`define EE_RW_READ         1'b1
`define EE_DEV_ADDR        7'h50
`define EE_READ_FILL       8'hff
`define EE_HI_ADDR_W       5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EE_CLK_MHZ         100
`define EE_WR_TIME_US      5000
`define EE_WR_TIME_MAX_US  7000
`define EE_WR_CYCLES       (`EE_WR_TIME_US * `EE_CLK_MHZ)
`define EE_TIMER_W         20

// ----------------------------------------------------------------
// Write buffer
// ----------------------------------------------------------------
`define EE_FIFO_DEPTH      32

`endif

// ### eeprom_port_pkg.sv
// Types shared by the two-wire secure EEPROM port
`include "eeprom_port_consts.svh"

package eeprom_port_pkg;

	// ----------------------------------------------------------------
	// Port state machine and byte position
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {stIdle, stRecv, stAckHold, stSend, stGetAck} port_state_t;
	typedef enum logic [1:0] {byDev, byAddrHi, byAddrLo, byData} byte_kind_t;

	// ----------------------------------------------------------------
	// Buffered write: target address and data byte
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [`EE_ADDR_W-1:0]    addr;
		logic [`EE_WORD_BITS-1:0] data;
	} write_entry_t;

	// Per-zone security class as configured at personalisation
	typedef logic [`EE_ZONE_COUNT-1:0][`EE_CLASS_W-1:0] zone_class_t;

endpackage : eeprom_port_pkg

// ### data_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module data_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 32
) (
	input  wire logic             clock,    // System clock
	input  wire logic             reset,    // Synchronous reset
	input  wire logic [WIDTH-1:0] inData,   // Word to store
	input  wire logic             inValid,  // Word offered
	output logic                  inReady,  // Room for a word
	output logic      [WIDTH-1:0] outData,  // Oldest word
	output logic                  outValid, // Word available
	input  wire logic             outReady  // Drain accepts word
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr_reg;
	logic [AW:0]      rdPtr_reg;

	// Full when pointers differ only in the wrap bit
	wire              empty = (wrPtr_reg == rdPtr_reg);
	wire              full  = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
	wire              push  = inValid && !full;
	wire              pop   = outValid && outReady;

	assign inReady  = !full;
	assign outValid = !empty;
	assign outData  = mem[rdPtr_reg[AW-1:0]];

	// Storage
	always_ff @(posedge clock)
	begin
		if (push)
			mem[wrPtr_reg[AW-1:0]] <= inData;
	end

	// Pointers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
		end
		else
		begin
			if (push)
				wrPtr_reg <= wrPtr_reg + 1'b1;
			if (pop)
				rdPtr_reg <= rdPtr_reg + 1'b1;
		end
	end

endmodule : data_fifo

`default_nettype wire

// ### two_wire_secure_eeprom_port.sv
// Two-wire serial target port with zoned, security-gated user memory
//
// Behaviour
// - Data changes only while clock low.
// - Data change during clock high is framing.
// - Start precedes commands; commands without one ignored.
// - Stop condition ends the current transfer.
// - Stop after read enters standby.
// - Eight-bit words, ninth clock acknowledge low.
// - Internal write finishes within write time.
// - Write time counted from the ending stop.
// - Sixteen 4096-bit zones, local addresses from zero.
// - Refuse zone access until security satisfied.
// - Same-class granted zones chain on; at the chain's end wrap to the last zone's start.
// - Sample on clock rise, shift on fall.
// - Data line driven open-drain only.
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_port_consts.svh"

module two_wire_secure_eeprom_port
	import eeprom_port_pkg::*;
#(
	parameter logic [6:0] DEVICE_ADDR  = `EE_DEV_ADDR,  // Target address, value arbitrary
	parameter int         WRITE_CYCLES = `EE_WR_CYCLES  // Internal write time in clocks
) (
	input  wire logic                           clock,       // 100 MHz system clock
	input  wire logic                           reset,       // Synchronous, active high
	input  wire logic                           sclIn,       // Serial clock pin
	input  wire logic                           sdaIn,       // Serial data pin level
	output logic                                sdaOut,      // Serial data drive value
	output logic                                sdaOe,       // Low while pulling data low
	input  wire logic [`EE_ZONE_COUNT-1:0]      zoneGranted, // Zone security satisfied
	input  wire eeprom_port_pkg::zone_class_t   zoneClass,   // Zone security class
	output logic                                standby,     // Standby power state
	output logic                                writeBusy    // Internal write cycle running
);
	import eeprom_port_pkg::*;

	// ----------------------------------------------------------------
	// Address helpers
	// ----------------------------------------------------------------

	// Next sequential address, crossing into the next zone only when it is merged
	function automatic logic [`EE_ADDR_W-1:0] nextAddr(
		input logic [`EE_ADDR_W-1:0]     addr,
		input logic [`EE_ZONE_COUNT-1:0] granted,
		input zone_class_t               cls
	);
		logic [`EE_ZONE_W-1:0] zone;
		logic [`EE_ZONE_W-1:0] nz;
		zone = addr[`EE_ADDR_W-1:`EE_LOCAL_W];
		nz   = zone + 1'b1;
		if (addr[`EE_LOCAL_W-1:0] != `EE_LOCAL_LAST)
			nextAddr = addr + 1'b1;
		else if (zone != `EE_LAST_ZONE && granted[nz] && cls[nz] == cls[zone])
			nextAddr = {nz, `EE_LOCAL_BASE};
		else
			nextAddr = {zone, `EE_LOCAL_BASE};
	endfunction : nextAddr

	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [1:0]  sclSync_reg;
	logic [1:0]  sdaSync_reg;
	logic        sclD_reg;
	logic        sdaD_reg;

	// Two synchroniser flops and one edge flop per pin; clock oversamples the serial clock well above its limit
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			sclSync_reg <= 2'h3;
			sdaSync_reg <= 2'h3;
			sclD_reg    <= 1'b1;
			sdaD_reg    <= 1'b1;
		end
		else
		begin
			sclSync_reg <= {sclSync_reg[0], sclIn};
			sdaSync_reg <= {sdaSync_reg[0], sdaIn};
			sclD_reg    <= sclSync_reg[1];
			sdaD_reg    <= sdaSync_reg[1];
		end
	end

	wire scl     = sclSync_reg[1];
	wire sda     = sdaSync_reg[1];
	wire sclRise = scl && !sclD_reg;
	wire sclFall = !scl && sclD_reg;
	wire sclHigh = scl && sclD_reg;
	// Data edge while clock stays high is framing, never a bit
	wire startEv = sclHigh && sdaD_reg && !sda;
	wire stopEv  = sclHigh && !sdaD_reg && sda;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	port_state_t                state_reg,    state_next;
	byte_kind_t                 kind_reg,     kind_next;
	logic [3:0]                 bitCnt_reg,   bitCnt_next;
	logic [`EE_WORD_BITS-1:0]   shift_reg,    shift_next;
	logic [`EE_ADDR_W-1:0]      addr_reg,     addr_next;
	logic                       readMode_reg, readMode_next;
	logic                       ackSeen_reg,  ackSeen_next;
	logic                       sdaOe_reg,    sdaOe_next;
	logic                       standby_reg,  standby_next;
	logic                       wrote_reg,    wrote_next;
	logic                       busy_reg,     busy_next;
	logic [`EE_TIMER_W-1:0]     timer_reg,    timer_next;
	logic [`EE_WORD_BITS-1:0]   memRd_reg;
	logic                       sdaOut_reg;

	logic [`EE_WORD_BITS-1:0]   mem [`EE_ZONE_COUNT*`EE_ZONE_BYTES];

	// ----------------------------------------------------------------
	// Write buffer between the serial side and the memory array
	// ----------------------------------------------------------------
	write_entry_t               fifoIn;
	write_entry_t               fifoOut;
	logic                       fifoInValid;
	logic                       fifoInReady;
	logic                       fifoOutValid;
	wire                        fifoOutReady = busy_reg;           // Drains only in the write cycle

	data_fifo #(
		.WIDTH ($bits(write_entry_t)),
		.DEPTH (`EE_FIFO_DEPTH)
	) writeBuffer (
		.clock    (clock),
		.reset    (reset),
		.inData   (fifoIn),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.outData  (fifoOut),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady)
	);

	// ----------------------------------------------------------------
	// Byte decoding
	// ----------------------------------------------------------------
	wire                        byteDone   = (state_reg == stRecv) && sclFall && (bitCnt_reg == `EE_BITCNT_FULL);
	wire                        devMatch   = (shift_reg[7:1] == DEVICE_ADDR) && !busy_reg;
	wire [`EE_ZONE_W-1:0]       curZone    = addr_reg[`EE_ADDR_W-1:`EE_LOCAL_W];
	wire                        zoneOk     = zoneGranted[curZone];
	wire                        dataAck    = zoneOk && fifoInReady;
	wire [`EE_WORD_BITS-1:0]    txByte     = zoneOk ? memRd_reg : `EE_READ_FILL;
	wire [`EE_ADDR_W-1:0]       addrInc    = nextAddr(addr_reg, zoneGranted, zoneClass);
	wire                        timerDone  = (timer_reg == `EE_TIMER_W'(WRITE_CYCLES - 1));

	assign fifoIn      = '{addr: addr_reg, data: shift_reg};
	assign fifoInValid = byteDone && (kind_reg == byData) && zoneOk;

	// ----------------------------------------------------------------
	// Serial state machine
	// ----------------------------------------------------------------

	// Next state of the bit engine, framing and write cycle
	always_comb
	begin
		state_next    = state_reg;
		kind_next     = kind_reg;
		bitCnt_next   = bitCnt_reg;
		shift_next    = shift_reg;
		addr_next     = addr_reg;
		readMode_next = readMode_reg;
		ackSeen_next  = ackSeen_reg;
		sdaOe_next    = sdaOe_reg;
		standby_next  = standby_reg;
		wrote_next    = wrote_reg;
		busy_next     = busy_reg;
		timer_next    = timer_reg;

		// Internal write cycle: drain buffer, count the write time
		if (busy_reg)
		begin
			if (!timerDone)
				timer_next = timer_reg + 1'b1;
			else if (!fifoOutValid)
				busy_next = 1'b0;
		end

		if (startEv)
		begin
			// Every command opens here; a start also ends standby
			state_next   = stRecv;
			kind_next    = byDev;
			bitCnt_next  = '0;
			sdaOe_next   = 1'b1;
			standby_next = 1'b0;
			readMode_next = 1'b0;
			wrote_next   = 1'b0;
		end
		else if (stopEv)
		begin
			state_next   = stIdle;
			sdaOe_next   = 1'b1;
			standby_next = readMode_reg;
			readMode_next = 1'b0;
			if (wrote_reg)
			begin
				busy_next  = 1'b1;
				timer_next = '0;
			end
			wrote_next   = 1'b0;
		end
		else
		begin
			unique case (state_reg)
				// Bus ignored until a start is seen
				stIdle:
				begin
					sdaOe_next = 1'b1;
				end
				stRecv:
				begin
					if (sclRise && bitCnt_reg != `EE_BITCNT_FULL)
					begin
						shift_next  = {shift_reg[6:0], sda};
						bitCnt_next = bitCnt_reg + 1'b1;
					end
					else if (byteDone)
					begin
						state_next = stAckHold;
						unique case (kind_reg)
							byDev:
							begin
								readMode_next = devMatch && (shift_reg[0] == `EE_RW_READ);
								kind_next     = byAddrHi;
								sdaOe_next    = !devMatch;
								if (!devMatch)
									state_next = stIdle;
							end
							byAddrHi:
							begin
								addr_next[`EE_ADDR_W-1:8] = shift_reg[`EE_HI_ADDR_W-1:0];
								kind_next  = byAddrLo;
								sdaOe_next = 1'b0;
							end
							byAddrLo:
							begin
								addr_next[7:0] = shift_reg;
								kind_next  = byData;
								sdaOe_next = !zoneOk;
								if (!zoneOk)
									state_next = stIdle;
							end
							byData:
							begin
								sdaOe_next = !dataAck;
								if (dataAck)
								begin
									addr_next  = addrInc;
									wrote_next = 1'b1;
								end
								else
									state_next = stIdle;
							end
						endcase
					end
				end
				// Ack held through the ninth clock; on its fall released, or the first read bit driven
				stAckHold:
				begin
					if (sclFall)
					begin
						if (readMode_reg && kind_reg == byAddrHi)
						begin
							sdaOe_next  = txByte[7];
							shift_next  = {txByte[6:0], 1'b0};
							addr_next   = addrInc;
							bitCnt_next = 4'h1;
							state_next  = stSend;
						end
						else
						begin
							sdaOe_next  = 1'b1;
							bitCnt_next = '0;
							state_next  = stRecv;
						end
					end
				end
				// Outgoing bits change only on clock fall
				stSend:
				begin
					if (sclFall)
					begin
						if (bitCnt_reg != `EE_BITCNT_FULL)
						begin
							sdaOe_next  = shift_reg[7];
							shift_next  = {shift_reg[6:0], 1'b0};
							bitCnt_next = bitCnt_reg + 1'b1;
						end
						else
						begin
							sdaOe_next = 1'b1;
							state_next = stGetAck;
						end
					end
				end
				// Host acknowledge sampled on rise; a release ends the read
				stGetAck:
				begin
					if (sclRise)
						ackSeen_next = !sda;
					else if (sclFall)
					begin
						if (ackSeen_reg)
						begin
							sdaOe_next  = txByte[7];
							shift_next  = {txByte[6:0], 1'b0};
							addr_next   = addrInc;
							bitCnt_next = 4'h1;
							state_next  = stSend;
						end
						else
							state_next = stIdle;
					end
				end
			endcase
		end
	end

	// State registers
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			state_reg    <= stIdle;
			kind_reg     <= byDev;
			bitCnt_reg   <= '0;
			shift_reg    <= '0;
			addr_reg     <= '0;
			readMode_reg <= 1'b0;
			ackSeen_reg  <= 1'b0;
			sdaOe_reg    <= 1'b1;
			standby_reg  <= 1'b0;
			wrote_reg    <= 1'b0;
			busy_reg     <= 1'b0;
			timer_reg    <= '0;
			sdaOut_reg   <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			kind_reg     <= kind_next;
			bitCnt_reg   <= bitCnt_next;
			shift_reg    <= shift_next;
			addr_reg     <= addr_next;
			readMode_reg <= readMode_next;
			ackSeen_reg  <= ackSeen_next;
			sdaOe_reg    <= sdaOe_next;
			standby_reg  <= standby_next;
			wrote_reg    <= wrote_next;
			busy_reg     <= busy_next;
			timer_reg    <= timer_next;
			sdaOut_reg   <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// User memory array
	// ----------------------------------------------------------------

	// Buffered bytes commit during the internal write cycle; read data staged
	always_ff @(posedge clock)
	begin
		if (fifoOutValid && fifoOutReady)
			mem[fifoOut.addr] <= fifoOut.data;
		memRd_reg <= mem[addr_reg];
	end

	// Outputs; line high comes only from the pull-up
	assign sdaOut    = sdaOut_reg;
	assign sdaOe     = sdaOe_reg;
	assign standby   = standby_reg;
	assign writeBusy = busy_reg;

endmodule : two_wire_secure_eeprom_port

`default_nettype wire

// ### eeprom_port_asserts.sv
// Pin-level checker for the two-wire EEPROM port
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_port_consts.svh"

module eeprom_port_asserts
	import eeprom_port_pkg::*;
#(
	parameter int WRITE_CYCLES = `EE_WR_CYCLES // Internal write time in clocks
) (
	input wire logic                         clock,       // System clock
	input wire logic                         reset,       // Synchronous reset
	input wire logic                         sclIn,       // Serial clock pin
	input wire logic                         sdaIn,       // Data wire level
	input wire logic                         sdaOut,      // Data drive value
	input wire logic                         sdaOe,       // Low while pulling low
	input wire logic [`EE_ZONE_COUNT-1:0]    zoneGranted, // Zone security met
	input wire eeprom_port_pkg::zone_class_t zoneClass,   // Zone classes
	input wire logic                         standby,     // Standby state
	input wire logic                         writeBusy    // Internal write running
);
	// ----------------------------------------------------------------
	// Bus events and timers
	// ----------------------------------------------------------------
	logic        sclQ;
	logic        sdaQ;
	logic [3:0]  sinceStop;
	logic [19:0] busyCnt;
	wire  logic  startEv = sclIn && sclQ && sdaQ && !sdaIn;
	wire  logic  stopEv  = sclIn && sclQ && !sdaQ && sdaIn;

	// Pin history, cycles since a stop, length of the busy spell
	always_ff @(posedge clock)
	begin
		sclQ      <= reset | sclIn;
		sdaQ      <= reset | sdaIn;
		sinceStop <= reset ? 4'hf : stopEv ? 4'h0 : sinceStop + {3'h0, sinceStop != 4'hf};
		busyCnt   <= writeBusy ? busyCnt + 20'h1 : 20'h0;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_open_drain: assert property (sdaOut == 1'b0)
		else $error("data pin driven high");
	a_move_scl_low: assert property (!$stable(sdaOe) |-> !sclIn)
		else $error("data drive moved with clock high");
	a_stop_releases: assert property (stopEv |=> sdaOe [*8])
		else $error("data pulled after stop");
	a_start_wakes: assert property (startEv |-> ##[1:8] !standby)
		else $error("standby kept after start");
	a_standby_on_stop: assert property ($rose(standby) |-> sinceStop <= 4'h8)
		else $error("standby without stop");
	a_busy_on_stop: assert property ($rose(writeBusy) |-> sinceStop <= 4'h8)
		else $error("write cycle without stop");
	a_busy_min_time: assert property ($fell(writeBusy) |-> busyCnt >= WRITE_CYCLES)
		else $error("write cycle too short");
	a_busy_max_time: assert property (writeBusy |-> busyCnt <= WRITE_CYCLES + 64)
		else $error("write cycle too long");
	a_busy_no_ack: assert property (writeBusy |-> sdaOe)
		else $error("acknowledge during write cycle");
	a_reset_idle: assert property (disable iff (1'b0) reset |=> sdaOe && !standby && !writeBusy)
		else $error("outputs not idle after reset");

	c_write: cover property ($rose(writeBusy));
	c_standby: cover property ($rose(standby));
	c_ack: cover property ($fell(sdaOe));

endmodule : eeprom_port_asserts

bind two_wire_secure_eeprom_port eeprom_port_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) eeprom_port_asserts_i (
	.clock(clock), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.zoneGranted(zoneGranted), .zoneClass(zoneClass), .standby(standby), .writeBusy(writeBusy));

`default_nettype wire

// ### host_model.sv
// Host controller model driving the two-wire serial bus
`timescale 1ns/100ps
`default_nettype none

module host_model (
	input  wire logic clock,   // System clock for pacing
	input  wire logic sdaWire, // Resolved data line
	output logic      sclOut,  // Serial clock, idle high
	output logic      sdaLow   // High while pulling data low
);
	// ----------------------------------------------------------------
	// Bus primitives, 80 ns bit period plus optional stretch
	// ----------------------------------------------------------------
	int stretch = 0; // Extra low cycles for a slow host

	// Idle bus: clock high, data released
	initial
	begin
		sclOut = 1'b1;
		sdaLow = 1'b0;
	end

	task automatic pause(input int n);
		repeat (n) @(posedge clock);
	endtask : pause

	// One clock pulse: data set mid-low, sampled late in the high phase
	task automatic bitCycle(input logic drvLow, output logic seen);
		pause(2 + stretch);
		sdaLow <= drvLow;
		pause(2);
		sclOut <= 1'b1;
		pause(4);
		seen = sdaWire;
		sclOut <= 1'b0;
	endtask : bitCycle

	task automatic startCond();
		pause(2);
		sdaLow <= 1'b0;
		pause(2);
		sclOut <= 1'b1;
		pause(4);
		sdaLow <= 1'b1;
		pause(4);
		sclOut <= 1'b0;
	endtask : startCond

	task automatic stopCond();
		pause(2);
		sdaLow <= 1'b1;
		pause(2);
		sclOut <= 1'b1;
		pause(4);
		sdaLow <= 1'b0;
		pause(4);
	endtask : stopCond

	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic seen;
		for (int i = 7; i >= 0; i--)
			bitCycle(~b[i], seen);
		bitCycle(1'b0, seen);
		ack = ~seen;
	endtask : sendByte

	task automatic recvByte(output logic [7:0] b, input logic ackIt);
		logic seen;
		for (int i = 7; i >= 0; i--)
		begin
			bitCycle(1'b0, seen);
			b[i] = seen;
		end
		bitCycle(ackIt, seen);
	endtask : recvByte

	// Clock with data released until the line reads high
	task automatic recover(output logic clear);
		logic seen;
		clear = 1'b0;
		@(posedge clock) sclOut <= 1'b0;
		for (int i = 0; i < 9 && !clear; i++)
		begin
			bitCycle(1'b0, seen);
			clear = seen;
		end
	endtask : recover

endmodule : host_model

`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the two-wire secure EEPROM port
`timescale 1ns/100ps
`default_nettype none
`include "eeprom_port_consts.svh"

module tb_top;
	import eeprom_port_pkg::*;

	typedef struct packed {
		logic [3:0] zone;
		logic [8:0] offset;
		logic [7:0] data;
		logic       ackLo;
	} row_t;

	localparam int         WR_CYC = 200;   // Shortened internal write time
	localparam logic [6:0] DEV    = 7'h2a; // Target address, value arbitrary

	logic                      clock       = 1'b0;
	logic                      reset       = 1'b1;
	logic                      sclIn;
	logic                      sdaLow;
	logic                      sda;
	logic                      sdaOut;
	logic                      sdaOe;
	logic                      standby;
	logic                      writeBusy;
	logic [`EE_ZONE_COUNT-1:0] zoneGranted = 16'hfff7;
	zone_class_t               zoneClass   = 64'h0000_0000_0100_0000;
	int                        num_errors  = 0;
	int                        compares    = 0;
	int                        cycles      = 0;
	logic                      ack;
	logic [7:0]                rd;
	row_t                      rows [3]    = '{'{4'h0, 9'h000, 8'ha5, 1'b1}, '{4'hf, 9'h1ff, 8'h3c, 1'b1},
	                                           '{4'h3, 9'h010, 8'h5a, 1'b0}};

	// ----------------------------------------------------------------
	// Clock, wire resolution, instances
	// ----------------------------------------------------------------
	always #5 clock = ~clock;
	assign sda = sdaLow ? 1'b0 : (sdaOe === 1'b0) ? sdaOut : 1'b1;

	two_wire_secure_eeprom_port #(.DEVICE_ADDR(DEV), .WRITE_CYCLES(WR_CYC)) two_wire_secure_eeprom_port_i (
		.clock(clock), .reset(reset), .sclIn(sclIn), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.zoneGranted(zoneGranted), .zoneClass(zoneClass), .standby(standby), .writeBusy(writeBusy));
	host_model host_model_i (.clock(clock), .sdaWire(sda), .sclOut(sclIn), .sdaLow(sdaLow));

	// Hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 50000)
		begin
			num_errors++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic finish_test();
		$display("Compares %0d, errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	task automatic waitIdle();
		for (int n = 0; n < 4000 && writeBusy !== 1'b0; n++)
			@(posedge clock);
		check("busyEnds", writeBusy, 8'h0);
	endtask : waitIdle

	task automatic setAddr(input logic [12:0] a, output logic ackLo);
		host_model_i.startCond();
		host_model_i.sendByte({DEV, 1'b0}, ackLo);
		host_model_i.sendByte({3'h0, a[12:8]}, ackLo);
		host_model_i.sendByte(a[7:0], ackLo);
	endtask : setAddr

	task automatic readOne(input logic [12:0] a, output logic [7:0] d);
		logic ok;
		setAddr(a, ok);
		host_model_i.startCond();
		host_model_i.sendByte({DEV, `EE_RW_READ}, ok);
		host_model_i.recvByte(d, 1'b0);
		host_model_i.stopCond();
	endtask : readOne

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		check("sdaOe", sdaOe, 8'h1);
		check("sdaOut", sdaOut, 8'h0);
		check("standby", standby, 8'h0);
		check("writeBusy", writeBusy, 8'h0);
		host_model_i.recover(ack);
		check("recoverClear", ack, 8'h1);
		host_model_i.sendByte({DEV, 1'b0}, ack);
		check("noStartAck", ack, 8'h0);
		host_model_i.stopCond();
		host_model_i.startCond();
		host_model_i.sendByte({~DEV, 1'b0}, ack);
		check("otherAddrAck", ack, 8'h0);
		host_model_i.stopCond();
		// Write, poll while busy, read back
		foreach (rows[i])
		begin
			setAddr({rows[i].zone, rows[i].offset}, ack);
			check("addrLoAck", ack, {7'h0, rows[i].ackLo});
			if (rows[i].ackLo)
			begin
				host_model_i.sendByte(rows[i].data, ack);
				check("dataAck", ack, 8'h1);
				host_model_i.stopCond();
				host_model_i.startCond();
				host_model_i.sendByte({DEV, 1'b0}, ack);
				check("pollAck", ack, 8'h0);
				host_model_i.stopCond();
				waitIdle();
				readOne({rows[i].zone, rows[i].offset}, rd);
				check("readBack", rd, rows[i].data);
				check("standby", standby, 8'h1);
			end
			else
				host_model_i.stopCond();
		end
		// Across a zone end: same class joins, other class wraps
		for (int k = 0; k < 2; k++)
		begin
			setAddr({4'h4 + 4'(2 * k), 9'h1ff}, ack);
			host_model_i.sendByte(8'h11, ack);
			host_model_i.sendByte(8'h22 + 8'(k), ack);
			host_model_i.stopCond();
			waitIdle();
			readOne({4'h5 + 4'(k), 9'h000}, rd);
			check("zoneEdge", rd, 8'h22 + 8'(k));
		end
		// Slow host fills the buffer until refused, then a two-byte read
		host_model_i.stretch = 3;
		setAddr({4'h1, 9'h000}, ack);
		for (int n = 0; n < 33; n++)
		begin
			host_model_i.sendByte(8'(n), ack);
			check("pageAck", ack, 8'(n < 32));
		end
		host_model_i.stopCond();
		waitIdle();
		setAddr({4'h1, 9'h01e}, ack);
		host_model_i.startCond();
		host_model_i.sendByte({DEV, `EE_RW_READ}, ack);
		host_model_i.recvByte(rd, 1'b1);
		check("pageRead", rd, 8'h1e);
		host_model_i.recvByte(rd, 1'b0);
		check("pageNext", rd, 8'h1f);
		host_model_i.stopCond();
		check("standbyEnd", standby, 8'h1);
		// Reset in mid-run returns the outputs to idle
		reset <= 1'b1;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		check("rstStandby", standby, 8'h0);
		check("rstOe", sdaOe, 8'h1);
		check("rstBusy", writeBusy, 8'h0);
		finish_test();
	end

endmodule : tb_top

`default_nettype wire
